// file: rtl/mua_map.svh
// Purpose: register offsets, field positions and reset values of the flag bank
// Assumes: byte-wide register access behind the two-wire serial engine
// Notes:   definitions only
`ifndef MUA_MAP_SVH
`define MUA_MAP_SVH

`define MUA_ADDR_UPDATE    8'h6f
`define MUA_ADDR_ALARM_A   8'h70
`define MUA_ADDR_ALARM_B   8'h71
`define MUA_LIMIT_END      8'h24
`define MUA_LIMIT_GAP_BIT  2
`define MUA_CH_MSB         5
`define MUA_CH_LSB         3
`define MUA_NUM_CH         3'd5
`define MUA_CH_TEMP        3'd0
`define MUA_UPD_TOP        7
`define MUA_UPD_RESET      5'h00
`define MUA_ALARM_RESET    10'h000
`define MUA_LIMIT_DEFAULT  32'h0000_0000
`define MUA_BYTE_ZERO      8'h00
`define MUA_LANE_TOP       4'h8
`define MUA_HI_TOP         31
`define MUA_HI_BOT         16
`define MUA_LO_TOP         15
`define MUA_ALM_B_HI       8
`define MUA_ALM_B_LO       9

`endif

// file: rtl/mua_pkg.sv
// Purpose: shared types of the monitor update and alarm flag bank
// Assumes: five monitored channels, 16-bit results and limits
// Notes:   offsets and field positions live in mua_map.svh
package mua_pkg;
  typedef logic [2:0]  mua_ch_t;
  typedef logic [7:0]  mua_byte_t;
  typedef logic [15:0] mua_meas_t;
  typedef logic [31:0] mua_limit_t;
endpackage

// file: rtl/mua_limit_mem.sv
// Purpose: limit store, one word per channel {hi msb, hi lsb, lo msb, lo lsb}
// Assumes: byte writes, two registered read ports
// Notes:   reset loads the factory default, standing in for the nonvolatile image
`timescale 1ns/1ns
`include "mua_map.svh"
module mua_limit_mem #(
  parameter int DW    = 32,
  parameter int DEPTH = 5,
  parameter int AW    = 3
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_we,
  input  wire logic [DW/8-1:0] i_be,
  input  wire logic [AW-1:0]   i_waddr,
  input  wire logic [DW-1:0]   i_wdata,
  input  wire logic [AW-1:0]   i_raddr_a,
  output logic      [DW-1:0]   o_rdata_a,
  input  wire logic [AW-1:0]   i_raddr_b,
  output logic      [DW-1:0]   o_rdata_b
);
  logic [DW-1:0] mem_ff     [DEPTH];
  logic [DW-1:0] nxt_mem    [DEPTH];

  always_comb begin
    for (int w = 0; w < DEPTH; w++) begin
      nxt_mem[w] = mem_ff[w];
      for (int b = 0; b < DW/8; b++) begin
        if (i_we && i_be[b] && (int'(i_waddr) == w)) begin
          nxt_mem[w][b*8 +: 8] = i_wdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int w = 0; w < DEPTH; w++) begin
      mem_ff[w] <= i_rst ? DW'(`MUA_LIMIT_DEFAULT) : nxt_mem[w];
    end
    o_rdata_a <= mem_ff[i_raddr_a];
    o_rdata_b <= mem_ff[i_raddr_b];
  end
endmodule

// file: rtl/mua_flags.sv
// Purpose: conversion-update flags and limit alarm flags of a monitoring device
// Assumes: byte register port behind the two-wire serial engine; measurement
//          results arrive as a strobe with channel index and 16-bit value
// Notes:   channel 0 temperature, 1 supply, 2..4 monitor inputs a, b, c
//
// Summary of operation
// - a temperature result strobe sets temp_update_flag, bit 7 of byte 6f.
// - host writes 0 to an update flag and it stays clear until that channel converts again.
// - a supply result strobe sets supply_update_flag, bit 6.
// - an input a result strobe sets input_a_update_flag, bit 5.
// - an input b result strobe sets input_b_update_flag, bit 4.
// - an input c result strobe sets input_c_update_flag, bit 3.
// - update flags reset to zero and bits 2 to 0 of byte 6f read zero.
// - byte 70 bits 7 and 6 are temp_high_alarm and temp_low_alarm, read only.
// - byte 70 bits 5 and 4 are supply_high_alarm and supply_low_alarm.
// - byte 70 bits 3 and 2 are input_a_high_alarm and input_a_low_alarm.
// - byte 70 bits 1 and 0 are input_b_high_alarm and input_b_low_alarm.
// - byte 71 bits 7 and 6 are input_c_high_alarm and input_c_low_alarm, others zero.
// - limits are host-writable two-byte words, msb first, default zero.
`timescale 1ns/1ns
`include "mua_map.svh"
module mua_flags
  import mua_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst,
  input  wire logic      i_wr_en,
  input  wire logic      i_rd_en,
  input  wire mua_byte_t i_addr,
  input  wire mua_byte_t i_wdata,
  output mua_byte_t      o_rdata,
  output logic           o_rvalid,
  input  wire logic      i_meas_stb,
  input  wire mua_ch_t   i_meas_ch,
  input  wire mua_meas_t i_meas_data
);
  localparam int NCH = 5;

  // limit bytes sit in groups of four every eight addresses
  function automatic logic lim_hit(input mua_byte_t a);
    lim_hit = (a < `MUA_LIMIT_END) && !a[`MUA_LIMIT_GAP_BIT];
  endfunction

  function automatic mua_ch_t lim_word(input mua_byte_t a);
    lim_word = a[`MUA_CH_MSB:`MUA_CH_LSB];
  endfunction

  // msb of the upper limit is byte 0 of its group, in the top lane
  function automatic logic [3:0] lim_lane(input mua_byte_t a);
    lim_lane = `MUA_LANE_TOP >> a[1:0];
  endfunction

  logic       [NCH-1:0]   upd_ff;
  logic       [NCH-1:0]   nxt_upd;
  logic       [2*NCH-1:0] alarm_ff;
  logic       [2*NCH-1:0] nxt_alarm;
  logic                   v1_ff;
  logic                   nxt_v1;
  mua_ch_t                ch1_ff;
  mua_ch_t                nxt_ch1;
  mua_meas_t              data1_ff;
  mua_meas_t              nxt_data1;
  logic                   rd1_ff;
  logic                   nxt_rd1;
  mua_byte_t              raddr1_ff;
  mua_byte_t              nxt_raddr1;
  mua_byte_t              rdata_ff;
  mua_byte_t              nxt_rdata;
  logic                   rvalid_ff;
  logic                   nxt_rvalid;
  mua_limit_t             lim_eval;
  mua_limit_t             lim_host;
  mua_byte_t              byte_upd;
  mua_byte_t              byte_alm_a;
  mua_byte_t              byte_alm_b;
  logic                   meas_ok;
  logic                   above;
  logic                   below;
  mua_meas_t              lim_hi;
  mua_meas_t              lim_lo;

  // strobes naming a channel beyond the fifth are dropped
  assign meas_ok = i_meas_stb && (i_meas_ch < `MUA_NUM_CH);

  mua_limit_mem #(
    .DW    (32),
    .DEPTH (NCH),
    .AW    (3)
  ) u_limits (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_we      (i_wr_en && lim_hit(i_addr)),
    .i_be      (lim_lane(i_addr)),
    .i_waddr   (lim_word(i_addr)),
    .i_wdata   ({4{i_wdata}}),
    .i_raddr_a (i_meas_ch),
    .o_rdata_a (lim_eval),
    .i_raddr_b (lim_word(i_addr)),
    .o_rdata_b (lim_host)
  );

  // ---- conversion-update flags
  always_comb begin
    nxt_upd = upd_ff;
    if (i_wr_en && (i_addr == `MUA_ADDR_UPDATE)) begin
      for (int k = 0; k < NCH; k++) begin
        // writing 1 has no effect; only hardware sets a flag
        if (!i_wdata[`MUA_UPD_TOP-k]) begin
          nxt_upd[k] = 1'b0;
        end
      end
    end
    // the set comes after the clear so a conversion in the clearing cycle wins
    if (meas_ok) begin
      nxt_upd[i_meas_ch] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    upd_ff <= i_rst ? `MUA_UPD_RESET : nxt_upd;
  end

  // ---- alarm evaluation, one result per cycle, limits read in the strobe cycle
  assign lim_hi = lim_eval[`MUA_HI_TOP:`MUA_HI_BOT];
  assign lim_lo = lim_eval[`MUA_LO_TOP:0];

  always_comb begin
    // temperature is two's complement, the other channels are unsigned
    if (ch1_ff == `MUA_CH_TEMP) begin
      above = $signed(data1_ff) > $signed(lim_hi);
      below = $signed(data1_ff) < $signed(lim_lo);
    end else begin
      above = data1_ff > lim_hi;
      below = data1_ff < lim_lo;
    end
  end

  always_comb begin
    nxt_v1    = meas_ok;
    nxt_ch1   = meas_ok ? i_meas_ch : ch1_ff;
    nxt_data1 = meas_ok ? i_meas_data : data1_ff;
    nxt_alarm = alarm_ff;
    if (v1_ff) begin
      nxt_alarm[{ch1_ff, 1'b0}] = above;
      nxt_alarm[{ch1_ff, 1'b1}] = below;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      v1_ff    <= 1'b0;
      ch1_ff   <= `MUA_CH_TEMP;
      data1_ff <= '0;
      alarm_ff <= `MUA_ALARM_RESET;
    end else begin
      v1_ff    <= nxt_v1;
      ch1_ff   <= nxt_ch1;
      data1_ff <= nxt_data1;
      alarm_ff <= nxt_alarm;
    end
  end

  // ---- byte views of the flags
  generate
    for (genvar k = 0; k < NCH; k++) begin : g_upd
      assign byte_upd[`MUA_UPD_TOP-k] = upd_ff[k];
    end
    for (genvar k = 0; k < 8; k++) begin : g_alm_a
      assign byte_alm_a[7-k] = alarm_ff[k];
    end
  endgenerate
  assign byte_upd[`MUA_UPD_TOP-NCH:0] = '0;
  assign byte_alm_b = {alarm_ff[`MUA_ALM_B_HI], alarm_ff[`MUA_ALM_B_LO], 6'h00};

  // ---- host read path: address in cycle 0, limit word in cycle 1, data in cycle 2
  always_comb begin
    nxt_rd1    = i_rd_en;
    nxt_raddr1 = i_rd_en ? i_addr : raddr1_ff;
    nxt_rvalid = rd1_ff;
    nxt_rdata  = rdata_ff;
    if (rd1_ff) begin
      if (lim_hit(raddr1_ff)) begin
        nxt_rdata = 8'(lim_host >> {~raddr1_ff[1:0], 3'b000});
      end else if (raddr1_ff == `MUA_ADDR_UPDATE) begin
        nxt_rdata = byte_upd;
      end else if (raddr1_ff == `MUA_ADDR_ALARM_A) begin
        nxt_rdata = byte_alm_a;
      end else if (raddr1_ff == `MUA_ADDR_ALARM_B) begin
        nxt_rdata = byte_alm_b;
      end else begin
        // unmapped and reserved bytes read zero
        nxt_rdata = `MUA_BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd1_ff    <= 1'b0;
      raddr1_ff <= `MUA_BYTE_ZERO;
      rdata_ff  <= `MUA_BYTE_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rd1_ff    <= nxt_rd1;
      raddr1_ff <= nxt_raddr1;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign o_rdata  = rdata_ff;
  assign o_rvalid = rvalid_ff;

  // ---- checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd(mua_byte_t a);
    i_rd_en && !i_wr_en && (i_addr == a) ##2 o_rvalid;
  endsequence

  sequence s_eval;
    meas_ok ##1 v1_ff;
  endsequence

  property p_upd_temp;
    i_meas_stb && (i_meas_ch == 3'd0) |=> upd_ff[0];
  endproperty
  a_upd_temp: assert property (p_upd_temp)
    else $error("temperature update flag not set");

  property p_upd_clear;
    i_wr_en && (i_addr == `MUA_ADDR_UPDATE) && !i_wdata[7] && !meas_ok
      ##1 (!(meas_ok && (i_meas_ch == 3'd0)))[*2] |=> !upd_ff[0];
  endproperty
  a_upd_clear: assert property (p_upd_clear)
    else $error("cleared update flag came back without a conversion");

  property p_upd_supply;
    i_meas_stb && (i_meas_ch == 3'd1) |=> upd_ff[1] && byte_upd[6];
  endproperty
  a_upd_supply: assert property (p_upd_supply)
    else $error("supply update flag not set");

  property p_upd_in_a;
    i_meas_stb && (i_meas_ch == 3'd2) |=> byte_upd[5];
  endproperty
  a_upd_in_a: assert property (p_upd_in_a)
    else $error("input a update flag not set");

  property p_upd_in_b;
    i_meas_stb && (i_meas_ch == 3'd3) |=> byte_upd[4];
  endproperty
  a_upd_in_b: assert property (p_upd_in_b)
    else $error("input b update flag not set");

  property p_upd_in_c;
    i_meas_stb && (i_meas_ch == 3'd4) |=> byte_upd[3];
  endproperty
  a_upd_in_c: assert property (p_upd_in_c)
    else $error("input c update flag not set");

  property p_upd_unused;
    s_rd(`MUA_ADDR_UPDATE) |-> (o_rdata[2:0] == 3'b000);
  endproperty
  a_upd_unused: assert property (p_upd_unused)
    else $error("unused update bits read nonzero");

  property p_alm_a_read;
    s_rd(`MUA_ADDR_ALARM_A) |-> (o_rdata[7] == $past(alarm_ff[0]))
      && (o_rdata[6] == $past(alarm_ff[1])) && (o_rdata[0] == $past(alarm_ff[7]));
  endproperty
  a_alm_a_read: assert property (p_alm_a_read)
    else $error("first alarm byte does not match alarm state");

  property p_alm_b_read;
    s_rd(`MUA_ADDR_ALARM_B) |-> (o_rdata[5:0] == 6'h00)
      && (o_rdata[7:6] == $past({alarm_ff[8], alarm_ff[9]}));
  endproperty
  a_alm_b_read: assert property (p_alm_b_read)
    else $error("second alarm byte malformed");

  property p_alm_high;
    s_eval ##0 (ch1_ff != `MUA_CH_TEMP) && (data1_ff > lim_hi)
      |=> alarm_ff[{$past(ch1_ff), 1'b0}];
  endproperty
  a_alm_high: assert property (p_alm_high)
    else $error("high alarm missed for result above upper limit");

  property p_alm_track;
    s_eval ##0 (data1_ff >= lim_lo) && (ch1_ff != `MUA_CH_TEMP)
      |=> !alarm_ff[{$past(ch1_ff), 1'b1}];
  endproperty
  a_alm_track: assert property (p_alm_track)
    else $error("low alarm stuck after result back within limit");

  property p_alm_quiet;
    !v1_ff |=> (alarm_ff == $past(alarm_ff));
  endproperty
  a_alm_quiet: assert property (p_alm_quiet)
    else $error("alarm changed without a new result");
endmodule

// file: test/mua_host_model.sv
// Purpose: host controller model driving the byte register port of the flag bank
// Assumes: one byte request per strobe cycle, read answered by o_rvalid
// Notes:   released address and data lines carry the inverse of the last value
`timescale 1ns/1ns
module mua_host_model
  import mua_pkg::*;
(
  input  wire logic      i_clk,
  output logic           o_wr_en,
  output logic           o_rd_en,
  output mua_byte_t      o_addr,
  output mua_byte_t      o_wdata,
  input  wire mua_byte_t i_rdata,
  input  wire logic      i_rvalid
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic put(input logic rd, input mua_byte_t a, input mua_byte_t d);
    @(posedge i_clk);
    o_rd_en <= rd;
    o_wr_en <= ~rd;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    o_wr_en <= 1'b0;
    // flipped so a stale byte is never mistaken for a live one
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic wr(input mua_byte_t a, input mua_byte_t d);
    put(1'b0, a, d);
  endtask

  task automatic rd(input mua_byte_t a, output mua_byte_t d, output logic ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    put(1'b1, a, 8'h00);
    for (n = 0; n < 6 && !ok; n++) begin
      @(posedge i_clk);
      if (i_rvalid === 1'b1) begin
        ok = 1'b1;
        d = i_rdata;
      end
    end
  endtask

  // zero written to every update flag, later polled by reads
  task automatic clear_flags();
    wr(8'h6f, 8'h00);
  endtask
endmodule

// file: test/testbench.sv
// Purpose: self-checking bench of the update and alarm flag bank
// Assumes: host model on the register port, bench drives the result strobe
// Notes:   table rows per channel, then clear, refusal and reset cases
`timescale 1ns/1ns
`include "mua_map.svh"
module testbench
  import mua_pkg::*;
;
  typedef struct {
    mua_ch_t   ch;
    mua_meas_t data;
    mua_meas_t hi;
    mua_meas_t lo;
    logic      ehi;
    logic      elo;
  } mua_row_t;

  logic      clk;
  logic      rst;
  logic      wr_en;
  logic      rd_en;
  mua_byte_t addr;
  mua_byte_t wdata;
  mua_byte_t rdata;
  logic      rvalid;
  logic      stb;
  mua_ch_t   ch;
  mua_meas_t data;
  int        failures;
  int        num_checks;
  int        cycles = 0;
  mua_byte_t exp70;
  mua_byte_t exp71;
  mua_row_t  r;
  mua_meas_t lim;

  // temperature compares signed, the rest unsigned; equal raises nothing
  mua_row_t rows [6] = '{
    '{3'd0, 16'hff00, 16'h0010, 16'hfff0, 1'b0, 1'b1},
    '{3'd1, 16'h8000, 16'h7fff, 16'h0000, 1'b1, 1'b0},
    '{3'd2, 16'h0100, 16'h0100, 16'h0100, 1'b0, 1'b0},
    '{3'd3, 16'h0050, 16'h0100, 16'h0060, 1'b0, 1'b1},
    '{3'd4, 16'h0200, 16'h01ff, 16'h0000, 1'b1, 1'b0},
    '{3'd0, 16'h0005, 16'h0010, 16'hfff0, 1'b0, 1'b0}
  };

  mua_flags dut_u (
    .i_clk       (clk),
    .i_rst       (rst),
    .i_wr_en     (wr_en),
    .i_rd_en     (rd_en),
    .i_addr      (addr),
    .i_wdata     (wdata),
    .o_rdata     (rdata),
    .o_rvalid    (rvalid),
    .i_meas_stb  (stb),
    .i_meas_ch   (ch),
    .i_meas_data (data)
  );

  mua_host_model host_u (
    .i_clk    (clk),
    .o_wr_en  (wr_en),
    .o_rd_en  (rd_en),
    .o_addr   (addr),
    .o_wdata  (wdata),
    .i_rdata  (rdata),
    .i_rvalid (rvalid)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input mua_byte_t a, input mua_byte_t e);
    mua_byte_t d;
    logic      ok;
    host_u.rd(a, d, ok);
    num_checks++;
    if (ok !== 1'b1 || d !== e) begin
      failures++;
      $display("ERROR t=%0t addr=%h got=%h exp=%h", $time, a, d, e);
    end
  endtask

  task automatic meas(input mua_ch_t c, input mua_meas_t v);
    @(posedge clk);
    stb  <= 1'b1;
    ch   <= c;
    data <= v;
    @(posedge clk);
    stb  <= 1'b0;
    ch   <= ~c;
    data <= ~v;
  endtask

  initial begin
    rst = 1'b1;
    stb = 1'b0;
    ch = 3'd0;
    data = 16'h0000;
    failures = 0;
    num_checks = 0;
    exp70 = 8'h00;
    exp71 = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      for (int k = 0; k < 4; k++) begin
        lim = (k < 2) ? r.hi : r.lo;
        host_u.wr({2'b00, r.ch, k[2:0]}, k[0] ? lim[7:0] : lim[15:8]);
      end
      host_u.clear_flags();
      meas(r.ch, r.data);
      if (r.ch == 3'd4) begin
        exp71 = {r.ehi, r.elo, 6'h00};
      end else begin
        exp70[7 - 2 * r.ch] = r.ehi;
        exp70[6 - 2 * r.ch] = r.elo;
      end
      chk(`MUA_ADDR_UPDATE, 8'h80 >> r.ch);
      chk(`MUA_ADDR_ALARM_A, exp70);
      chk(`MUA_ADDR_ALARM_B, exp71);
      $display("row %0d done", i);
    end
    host_u.clear_flags();
    repeat (20) @(posedge clk);
    chk(`MUA_ADDR_UPDATE, 8'h00);
    host_u.wr(`MUA_ADDR_UPDATE, 8'hff);
    chk(`MUA_ADDR_UPDATE, 8'h00);
    host_u.wr(`MUA_ADDR_ALARM_A, ~exp70);
    chk(`MUA_ADDR_ALARM_A, exp70);
    // limit bytes read back msb first; the gap byte ignores writes
    chk(8'h08, 8'h7f);
    chk(8'h1b, 8'h60);
    host_u.wr(8'h0c, 8'ha5);
    chk(8'h0c, 8'h00);
    $display("clear and read-only test done");
    fork
      host_u.clear_flags();
      meas(3'd3, 16'h0000);
    join
    chk(`MUA_ADDR_UPDATE, 8'h10);
    host_u.clear_flags();
    meas(3'd5, 16'hffff);
    chk(`MUA_ADDR_UPDATE, 8'h00);
    $display("collision test done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(`MUA_ADDR_UPDATE, 8'h00);
    chk(`MUA_ADDR_ALARM_A, 8'h00);
    chk(`MUA_ADDR_ALARM_B, 8'h00);
    meas(3'd1, 16'h0001);
    chk(`MUA_ADDR_ALARM_A, 8'h20);
    $display("reset test done");
    tally_and_finish();
  end
endmodule
